// ### dl_pcs.sv
/*
 * Deterministic-latency PCS channel: register port, fixed-depth TX and RX
 * fabric pipelines, toggle handshakes to the link word-clock domain, TX bit
 * slip, manual word aligner with slip report, PFD feedback select.
 * Assumes link_clk runs faster than clk and tx_data comes from clk logic.
 */
// The implementer's own choices: the address-and-strobe port and the register offsets.
// Overview of operation
// [R1] Bonding is a control bit that selects the shared core clock instead of the per-channel clock.
// [R2] The RX phase compensation stage is always a single register, TX chooses registered or FIFO depth.
// [R3] A registered phase compensation stage is one fixed register so its delay never varies.
// [R4] The word aligner matches a programmable 10-bit pattern only when software asks for alignment.
// [R5] After a manual alignment the number of slipped bits is shown as a 5-bit unsigned count.
// [R6] Every new alignment request re-runs the search and refreshes the slip count.
// [R7] The serial output is delayed by the number of bits on the slip-select input.
// [R8] Slip values from zero to nine bits are honoured, larger ones are clamped to nine.
// [R9] Fabric logic picks the TX slip from the reported RX slip to keep round trip fixed.
// [R10] PFD feedback is offered only while the reference clock matches the parallel clock.
// [R11] With PFD feedback enabled the PLL is told to use the parallel clock path as feedback.
// [R12] The fabric interface is 8, 10, 16 or 20 bits wide by a control field.
// [R13] The TX fabric path has a fixed latency of four clock cycles; the code taps one stage later when the TX registered bit is clear.
// [R14] The RX fabric path has 5 or 8 cycles of pipeline, giving 5-6 or 8-9 with crossing.
// [R15] A slip change is applied only at a word boundary so other bits stay intact.
module dl_pcs import dl_pcs_pkg::*; #(
   parameter int TX_LAT_CYC = TX_LAT,
   parameter int RX_NARROW_CYC = RX_LAT_NARROW,
   parameter int RX_WIDE_CYC = RX_LAT_WIDE
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [FAB_W-1:0] tx_data,
   input wire logic [SLIP_W-1:0] tx_slip_sel,
   output logic [FAB_W-1:0] rx_data,
   output logic rx_valid,
   output logic [SLIP_W-1:0] rx_slip_count,
   output logic rx_synced,
   input wire logic ref_match,
   output logic pfd_fb_sel,
   output logic core_clk_sel,
   input wire logic link_clk,
   input wire logic [LINK_W-1:0] rx_word,
   output logic [LINK_W-1:0] tx_word
);

   generate
      if (TX_LAT_CYC < 2 || RX_NARROW_CYC < 2 || RX_WIDE_CYC < RX_NARROW_CYC) begin : g_bad
         $error("dl_pcs: latency parameters out of range");
      end
   endgenerate

   typedef enum {A_IDLE, A_HUNT, A_LOCK} align_t;

   function automatic logic [LINK_W-1:0] slip_win(input logic [2*LINK_W-1:0] cat,
                                                  input logic [SLIP_W-1:0] sh);
      logic [2*LINK_W-1:0] t;
      t = cat >> sh;
      return t[LINK_W-1:0];
   endfunction

   function automatic logic [LINK_W-1:0] sym_of(input logic [FAB_W-1:0] d, input width_t w,
                                                 input logic hi);
      logic [LINK_W-1:0] s;
      s = '0;
      unique case (w)
         W8: s = {2'b00, d[7:0]};
         W10: s = d[9:0];
         W16: s = hi ? {2'b00, d[15:8]} : {2'b00, d[7:0]};
         W20: s = hi ? d[19:10] : d[9:0];
      endcase
      return s;
   endfunction

   // Fabric clock domain
   logic [CTRL_W-1:0] ctrl_reg;
   logic [LINK_W-1:0] pat_reg;
   logic ref_s1_reg, ref_s2_reg;
   logic pfd_fb_reg, core_clk_reg;
   logic [31:0] rdata_reg;
   width_t width;

   assign width = width_t'(ctrl_reg[CTRL_WIDTH_LSB +: 2]);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_reg <= CTRL_RST;
         pat_reg <= PAT_RST;
      end else if (reg_wr) begin
         if (reg_addr == CTRL_ADDR) begin
            ctrl_reg <= reg_wdata[CTRL_W-1:0];
         end
         if (reg_addr == PAT_ADDR) begin
            pat_reg <= reg_wdata[LINK_W-1:0];
         end
      end
   end

   // Reference match pin synchroniser
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ref_s1_reg <= 1'b0;
         ref_s2_reg <= 1'b0;
      end else begin
         ref_s1_reg <= ref_match;
         ref_s2_reg <= ref_s1_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pfd_fb_reg <= 1'b0;
         core_clk_reg <= 1'b0;
      end else begin
         // [R10] [R11] PFD feedback gating
         pfd_fb_reg <= ctrl_reg[CTRL_PFD_BIT] & ref_s2_reg;
         // [R1] bonded clock select
         core_clk_reg <= ctrl_reg[CTRL_BOND_BIT];
      end
   end

   assign pfd_fb_sel = pfd_fb_reg;
   assign core_clk_sel = core_clk_reg;

   // TX fabric pipeline and launch
   tx_xfer_t tx_pipe [TX_LAT_CYC+1];
   tx_xfer_t tx_in, tx_hold_reg;
   logic tx_req_reg, tx_ack_s1_reg, tx_ack_s2_reg;
   logic tx_ack_reg;
   int tx_tap;

   always_comb begin
      tx_in.data = tx_data;
      // [R7] [R8] slip select clamped to nine
      tx_in.slip = (tx_slip_sel > TX_SLIP_MAX) ? TX_SLIP_MAX : tx_slip_sel;
      tx_in.width = width;
      tx_in.pat = pat_reg;
      tx_in.align_en = ctrl_reg[CTRL_ALIGN_BIT];
      // [R2] [R3] [R13] registered mode is one stage shorter
      tx_tap = ctrl_reg[CTRL_TXREG_BIT] ? TX_LAT_CYC - 1 : TX_LAT_CYC;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i <= TX_LAT_CYC; i++) begin
            tx_pipe[i] <= '0;
         end
      end else begin
         tx_pipe[0] <= tx_in;
         for (int i = 1; i <= TX_LAT_CYC; i++) begin
            tx_pipe[i] <= tx_pipe[i-1];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_ack_s1_reg <= 1'b0;
         tx_ack_s2_reg <= 1'b0;
         tx_req_reg <= 1'b0;
         tx_hold_reg <= '0;
      end else begin
         tx_ack_s1_reg <= tx_ack_reg;
         tx_ack_s2_reg <= tx_ack_s1_reg;
         if (tx_req_reg == tx_ack_s2_reg) begin
            tx_hold_reg <= tx_pipe[tx_tap];
            tx_req_reg <= ~tx_req_reg;
         end
      end
   end

   // RX capture from link and fixed pipeline
   rx_xfer_t rx_hold_reg;
   logic rx_req_reg, rx_ack_reg;
   logic rx_req_s1_reg, rx_req_s2_reg;
   rx_xfer_t rx_pipe [RX_WIDE_CYC];
   rx_xfer_t rx_out_reg;
   int rx_tap;

   // [R14] narrow or wide RX depth
   assign rx_tap = (width == W16 || width == W20) ? RX_WIDE_CYC - 2 : RX_NARROW_CYC - 2;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_req_s1_reg <= 1'b0;
         rx_req_s2_reg <= 1'b0;
         rx_ack_reg <= 1'b0;
      end else begin
         rx_req_s1_reg <= rx_req_reg;
         rx_req_s2_reg <= rx_req_s1_reg;
         rx_ack_reg <= rx_req_s2_reg;
      end
   end

   // [R2] [R3] single-register RX phase compensation then fixed delay
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < RX_WIDE_CYC; i++) begin
            rx_pipe[i] <= '0;
         end
         rx_out_reg <= '0;
      end else begin
         rx_pipe[0] <= (rx_req_s2_reg != rx_ack_reg) ? rx_hold_reg : rx_pipe[0];
         rx_pipe[0].valid <= rx_req_s2_reg != rx_ack_reg;
         for (int i = 1; i < RX_WIDE_CYC; i++) begin
            rx_pipe[i] <= rx_pipe[i-1];
         end
         rx_out_reg <= rx_pipe[rx_tap];
      end
   end

   assign rx_data = rx_out_reg.data;
   assign rx_valid = rx_out_reg.valid;
   // [R5] slip count on the fabric port
   assign rx_slip_count = rx_out_reg.slip_cnt;
   assign rx_synced = rx_out_reg.synced;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= '0;
         if (reg_rd) begin
            unique case (reg_addr)
               CTRL_ADDR: rdata_reg[CTRL_W-1:0] <= ctrl_reg;
               PAT_ADDR: rdata_reg[LINK_W-1:0] <= pat_reg;
               STAT_ADDR: begin
                  rdata_reg[STAT_SLIP_LSB +: SLIP_W] <= rx_out_reg.slip_cnt;
                  rdata_reg[STAT_SYNC_BIT] <= rx_out_reg.synced;
                  rdata_reg[STAT_PFD_BIT] <= pfd_fb_reg;
               end
               default: rdata_reg <= '0;
            endcase
         end
      end
   end

   assign reg_rdata = rdata_reg;

   // Link clock domain
   logic lrst_s1_reg, lrst_reg;
   logic ltx_s1_reg, ltx_s2_reg;
   tx_xfer_t tx_cap_reg;
   logic hi_pend_reg;
   logic [LINK_W-1:0] cur_sym_reg, prev_sym_reg, tx_word_reg;

   // Reset carried into the link domain
   always_ff @(posedge link_clk) begin
      lrst_s1_reg <= sys_rst;
      lrst_reg <= lrst_s1_reg;
   end

   always_ff @(posedge link_clk) begin
      if (lrst_reg) begin
         ltx_s1_reg <= 1'b0;
         ltx_s2_reg <= 1'b0;
         tx_ack_reg <= 1'b0;
      end else begin
         ltx_s1_reg <= tx_req_reg;
         ltx_s2_reg <= ltx_s1_reg;
         tx_ack_reg <= ltx_s2_reg;
      end
   end

   // Word capture and byte serialiser
   always_ff @(posedge link_clk) begin
      if (lrst_reg) begin
         tx_cap_reg <= '0;
         hi_pend_reg <= 1'b0;
         cur_sym_reg <= '0;
         prev_sym_reg <= '0;
      end else begin
         prev_sym_reg <= cur_sym_reg;
         if (ltx_s2_reg != tx_ack_reg) begin
            // [R15] slip and data change together at a word boundary
            tx_cap_reg <= tx_hold_reg;
            cur_sym_reg <= sym_of(tx_hold_reg.data, tx_hold_reg.width, 1'b0);
            hi_pend_reg <= tx_hold_reg.width == W16 || tx_hold_reg.width == W20;
         end else if (hi_pend_reg) begin
            cur_sym_reg <= sym_of(tx_cap_reg.data, tx_cap_reg.width, 1'b1);
            hi_pend_reg <= 1'b0;
         end else begin
            cur_sym_reg <= '0;
         end
      end
   end

   // [R7] [R8] bit delay across the previous symbol
   always_ff @(posedge link_clk) begin
      if (lrst_reg) begin
         tx_word_reg <= '0;
      end else begin
         tx_word_reg <= slip_win({cur_sym_reg, prev_sym_reg}, SLIP_W'(LINK_W) - tx_cap_reg.slip);
      end
   end

   assign tx_word = tx_word_reg;

   // Word aligner
   align_t align_reg;
   logic [LINK_W-1:0] rx_cur_reg, rx_prev_reg, al_sym_reg, rx_lo_reg;
   logic [SLIP_W-1:0] off_reg;
   logic align_en_d_reg, al_valid_reg, rx_half_reg;
   logic lrx_ack_s1_reg, lrx_ack_s2_reg;
   logic found;
   logic [SLIP_W-1:0] found_off;
   logic wide;

   assign wide = tx_cap_reg.width == W16 || tx_cap_reg.width == W20;

   // [R4] search all ten offsets, lowest wins
   always_comb begin
      found = 1'b0;
      found_off = '0;
      for (int i = LINK_W - 1; i >= 0; i--) begin
         if (slip_win({rx_cur_reg, rx_prev_reg}, SLIP_W'(i)) == tx_cap_reg.pat) begin
            found = 1'b1;
            found_off = SLIP_W'(i);
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst_reg) begin
         rx_cur_reg <= '0;
         rx_prev_reg <= '0;
         align_en_d_reg <= 1'b0;
         align_reg <= A_IDLE;
         off_reg <= '0;
      end else begin
         rx_cur_reg <= rx_word;
         rx_prev_reg <= rx_cur_reg;
         align_en_d_reg <= tx_cap_reg.align_en;
         unique case (align_reg)
            A_IDLE, A_LOCK: begin
               // [R6] each request starts a fresh search
               if (tx_cap_reg.align_en && !align_en_d_reg) begin
                  align_reg <= A_HUNT;
               end
            end
            A_HUNT: begin
               if (found) begin
                  // [R5] bits slipped to reach lock
                  off_reg <= found_off;
                  align_reg <= A_LOCK;
               end
            end
         endcase
      end
   end

   // Aligned symbols, byte deserialiser and launch
   always_ff @(posedge link_clk) begin
      if (lrst_reg) begin
         al_sym_reg <= '0;
         al_valid_reg <= 1'b0;
         rx_half_reg <= 1'b0;
         rx_lo_reg <= '0;
         lrx_ack_s1_reg <= 1'b0;
         lrx_ack_s2_reg <= 1'b0;
         rx_req_reg <= 1'b0;
         rx_hold_reg <= '0;
      end else begin
         lrx_ack_s1_reg <= rx_ack_reg;
         lrx_ack_s2_reg <= lrx_ack_s1_reg;
         al_sym_reg <= slip_win({rx_cur_reg, rx_prev_reg}, off_reg);
         al_valid_reg <= align_reg == A_LOCK;
         if (!al_valid_reg) begin
            rx_half_reg <= 1'b0;
         end else if (wide && !rx_half_reg) begin
            rx_lo_reg <= al_sym_reg;
            rx_half_reg <= 1'b1;
         end else begin
            rx_half_reg <= 1'b0;
            if (rx_req_reg == lrx_ack_s2_reg) begin
               rx_req_reg <= ~rx_req_reg;
               rx_hold_reg.valid <= 1'b1;
               rx_hold_reg.slip_cnt <= off_reg;
               rx_hold_reg.synced <= 1'b1;
               unique case (tx_cap_reg.width)
                  W8: rx_hold_reg.data <= {12'h000, al_sym_reg[7:0]};
                  W10: rx_hold_reg.data <= {10'h000, al_sym_reg};
                  W16: rx_hold_reg.data <= {4'h0, al_sym_reg[7:0], rx_lo_reg[7:0]};
                  W20: rx_hold_reg.data <= {al_sym_reg, rx_lo_reg};
               endcase
            end
         end
      end
   end

endmodule

// ### dl_pcs_assertions.sv
/*
 * Port checker for the deterministic-latency PCS channel.
 * Assumes it is bound to dl_pcs and sees only that module's ports.
 */
module dl_pcs_assertions import dl_pcs_pkg::*; #(
   parameter int TX_LAT_CYC = TX_LAT,
   parameter int RX_NARROW_CYC = RX_LAT_NARROW,
   parameter int RX_WIDE_CYC = RX_LAT_WIDE
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [FAB_W-1:0] tx_data,
   input wire logic [SLIP_W-1:0] tx_slip_sel,
   input wire logic [FAB_W-1:0] rx_data,
   input wire logic rx_valid,
   input wire logic [SLIP_W-1:0] rx_slip_count,
   input wire logic rx_synced,
   input wire logic ref_match,
   input wire logic pfd_fb_sel,
   input wire logic core_clk_sel,
   input wire logic link_clk,
   input wire logic [LINK_W-1:0] rx_word,
   input wire logic [LINK_W-1:0] tx_word
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [CTRL_W-1:0] ctrl_sh;
   logic [LINK_W-1:0] pat_sh;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Mirror of the control and pattern registers as written
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_sh <= CTRL_RST;
         pat_sh <= PAT_RST;
      end else if (reg_wr && reg_addr == CTRL_ADDR) begin
         ctrl_sh <= reg_wdata[CTRL_W-1:0];
      end else if (reg_wr && reg_addr == PAT_ADDR) begin
         pat_sh <= reg_wdata[LINK_W-1:0];
      end
   end
   chk_ctrl_readback: assert property (
      reg_rd && reg_addr == CTRL_ADDR |=> reg_rdata == {26'h0, ctrl_sh})
      else $error("control readback wrong");
   chk_pat_readback: assert property (
      reg_rd && reg_addr == PAT_ADDR |=> reg_rdata == {22'h0, pat_sh})
      else $error("pattern readback wrong");
   chk_status_read: assert property (
      reg_rd && reg_addr == STAT_ADDR |=>
      reg_rdata == {25'h0, $past(pfd_fb_sel), $past(rx_synced), $past(rx_slip_count)})
      else $error("status readback wrong");
   chk_rdata_idle: assert property (
      !reg_rd || reg_addr == 4'hc |=> reg_rdata == 32'h0)
      else $error("read data not zero");
   chk_valid_pulse: assert property (
      rx_valid |=> !rx_valid)
      else $error("receive valid longer than one cycle");
   chk_slip_bound: assert property (
      rx_synced |-> rx_slip_count <= 5'h09)
      else $error("slip count beyond pattern length");
   chk_pfd_gate: assert property (
      (!ref_match) [*4] |-> !pfd_fb_sel)
      else $error("feedback offered without clock match");
   chk_pfd_enable: assert property (
      (!ctrl_sh[CTRL_PFD_BIT]) [*3] |-> !pfd_fb_sel)
      else $error("feedback selected while disabled");
   chk_bond_follow: assert property (
      $stable(ctrl_sh) [*3] |-> core_clk_sel == ctrl_sh[CTRL_BOND_BIT])
      else $error("core clock select does not follow bonding");
   cover property (rx_valid && rx_slip_count == 5'h09);
   cover property ($rose(pfd_fb_sel));
   cover property (reg_rd && reg_addr == STAT_ADDR);
endmodule

bind dl_pcs dl_pcs_assertions #(.TX_LAT_CYC(TX_LAT_CYC), .RX_NARROW_CYC(RX_NARROW_CYC),
   .RX_WIDE_CYC(RX_WIDE_CYC)) u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
   .tx_slip_sel(tx_slip_sel), .rx_data(rx_data), .rx_valid(rx_valid), .rx_slip_count(rx_slip_count),
   .rx_synced(rx_synced), .ref_match(ref_match), .pfd_fb_sel(pfd_fb_sel), .core_clk_sel(core_clk_sel),
   .link_clk(link_clk), .rx_word(rx_word), .tx_word(tx_word));

// ### dl_pcs_pkg.sv
/*
 * Constants, field layout and carrier types for the deterministic-latency PCS.
 * Assumes a single fabric clock domain plus one link word-clock domain.
 */
package dl_pcs_pkg;

   localparam int LINK_W = 10;
   localparam int FAB_W = 20;
   localparam int SLIP_W = 5;
   localparam logic [SLIP_W-1:0] TX_SLIP_MAX = 5'h09;

   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] PAT_ADDR = 4'h4;
   localparam logic [3:0] STAT_ADDR = 4'h8;

   localparam int CTRL_W = 6;
   localparam int CTRL_WIDTH_LSB = 0;
   localparam int CTRL_TXREG_BIT = 2;
   localparam int CTRL_BOND_BIT = 3;
   localparam int CTRL_PFD_BIT = 4;
   localparam int CTRL_ALIGN_BIT = 5;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h05;
   localparam logic [LINK_W-1:0] PAT_RST = 10'h0fa;

   localparam int STAT_SLIP_LSB = 0;
   localparam int STAT_SYNC_BIT = 5;
   localparam int STAT_PFD_BIT = 6;

   localparam int TX_LAT = 4;
   localparam int RX_LAT_NARROW = 5;
   localparam int RX_LAT_WIDE = 8;

   typedef enum logic [1:0] {W8, W10, W16, W20} width_t;

   typedef struct packed {
      logic [FAB_W-1:0] data;
      logic [SLIP_W-1:0] slip;
      width_t width;
      logic [LINK_W-1:0] pat;
      logic align_en;
   } tx_xfer_t;

   typedef struct packed {
      logic valid;
      logic [FAB_W-1:0] data;
      logic [SLIP_W-1:0] slip_cnt;
      logic synced;
   } rx_xfer_t;

endpackage

// ### link_partner.sv
/*
 * Serial link partner sending the alignment pattern on every word clock.
 * Assumes the receiver assembles words bit 0 first.
 */
module link_partner import dl_pcs_pkg::*; (
   input wire logic link_clk,
   input wire logic [3:0] off,
   input wire logic [LINK_W-1:0] pat,
   output logic [LINK_W-1:0] rx_word
);
   timeunit 1ns;
   timeprecision 100ps;
   // Pattern rotated so the receiver finds it after off slipped bits
   always_ff @(posedge link_clk) begin
      rx_word <= LINK_W'(({pat, pat} << off) >> LINK_W);
   end
endmodule

// ### testbench.sv
/*
 * Self-checking bench for the deterministic-latency PCS channel.
 * Assumes the checker is bound in and the partner drives the link.
 */
module testbench;
   import dl_pcs_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ref_match = 1'b0;
   logic [3:0] reg_addr = 4'h0, off = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [FAB_W-1:0] tx_data = 20'h002d3, rx_data;
   logic [SLIP_W-1:0] tx_slip_sel = 5'h00, rx_slip_count;
   logic [LINK_W-1:0] rx_word, tx_word, tx_exp = 10'h000;
   logic rx_valid, rx_synced, pfd_fb_sel, core_clk_sel;
   int failures = 0, checks = 0, n, tx_hits = 0;
   int ks[4] = '{1, 0, 9, 4};

   initial begin
      forever #50 clk = ~clk;
   end
   initial begin
      #3.3;
      forever #7.5 link_clk = ~link_clk;
   end

   dl_pcs u_dl_pcs (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_slip_sel(tx_slip_sel),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_slip_count(rx_slip_count), .rx_synced(rx_synced),
      .ref_match(ref_match), .pfd_fb_sel(pfd_fb_sel), .core_clk_sel(core_clk_sel), .link_clk(link_clk),
      .rx_word(rx_word), .tx_word(tx_word));
   link_partner u_link_partner (.link_clk(link_clk), .off(off), .pat(PAT_RST), .rx_word(rx_word));

   // Counts link symbols equal to the expected slipped symbol
   always @(posedge link_clk) begin
      if (tx_word === tx_exp) tx_hits <= tx_hits + 1;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic guard();
      if (n >= 400) begin
         failures++;
         end_sim();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic tx_case(input logic [4:0] s, input int e);
      int h;
      @(posedge clk);
      tx_slip_sel <= s;
      repeat (12) @(posedge clk);
      tx_exp = LINK_W'(tx_data[LINK_W-1:0] << e);
      h = tx_hits;
      n = 0;
      while (tx_hits == h && n < 400) begin
         @(posedge clk);
         n++;
      end
      guard();
      chk(32'(tx_hits != h), 32'h1);
   endtask
   task automatic lock(input logic [3:0] k);
      @(posedge clk);
      off <= k;
      wr(CTRL_ADDR, 32'h05);
      repeat (20) @(posedge clk);
      wr(CTRL_ADDR, 32'h25);
      n = 0;
      while (!(rx_valid === 1'b1 && rx_slip_count === 5'(k)) && n < 400) begin
         @(negedge clk);
         n++;
      end
      guard();
   endtask

   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rdchk(CTRL_ADDR, 32'h05);
      rdchk(PAT_ADDR, 32'h0fa);
      rdchk(STAT_ADDR, 32'h0);
      wr(4'hc, 32'hffff_ffff);
      rdchk(4'hc, 32'h0);
      wr(PAT_ADDR, 32'hffff_f0fa);
      rdchk(PAT_ADDR, 32'h0fa);
      wr(CTRL_ADDR, 32'h0d);
      rdchk(CTRL_ADDR, 32'h0d);
      chk(core_clk_sel, 32'h1);
      wr(CTRL_ADDR, 32'h11);
      repeat (5) @(negedge clk);
      chk(pfd_fb_sel, 32'h0);
      @(posedge clk);
      ref_match <= 1'b1;
      repeat (5) @(negedge clk);
      chk(pfd_fb_sel, 32'h1);
      chk(core_clk_sel, 32'h0);
      rdchk(STAT_ADDR, 32'h40);
      for (int i = 0; i < 4; i++) begin
         lock(ks[i][3:0]);
         chk(rx_data, 32'(PAT_RST));
         chk(rx_slip_count, ks[i]);
         chk(rx_synced, 32'h1);
         // Transmit slip chosen to keep the round trip fixed
         tx_case(5'(9 - ks[i]), 9 - ks[i]);
      end
      rdchk(STAT_ADDR, 32'h24);
      tx_case(5'h0c, 9);
      tx_case(5'h00, 0);
      wr(CTRL_ADDR, 32'h27);
      // Let narrow words still in flight drain before looking
      repeat (40) @(negedge clk);
      n = 0;
      while (rx_valid !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      guard();
      chk(rx_data, 32'h3e8fa);
      end_sim();
   end
endmodule
